// ### ts_mon_pkg.sv
// package: constants and carriers for the transport stream monitor
package ts_mon_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;   // control, read/write
  localparam logic [3:0] STATUS_OFS = 4'h4; // status, read only

  // control fields
  localparam int ILV_SEL_POS = 0;   // interleave selection, 2 bits
  localparam int RS_SEL_POS = 2;    // reed-solomon selection, 2 bits
  localparam int SCR_SEL_POS = 4;   // scrambling selection, 2 bits
  localparam int LINK_POS = 8;      // alarm_source_link
  localparam logic [8:0] CTRL_RST = 9'h000; // all centred, link out

  // selection switch positions
  localparam logic [1:0] SEL_CENTRE = 2'h0; // bypass
  localparam logic [1:0] SEL_UP = 2'h1;     // decode path
  localparam logic [1:0] SEL_DOWN = 2'h2;   // encode path

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // stream constants
  // ---------------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'h47;  // normal sync
  localparam logic [7:0] SYNC_INV = 8'hb8;   // inverted sync
  localparam logic [7:0] LEN_SHORT = 8'hbc;  // 188 bytes
  localparam logic [7:0] LEN_LONG = 8'hcc;   // 204 bytes
  localparam logic [2:0] MISS_LIMIT = 3'h2;  // misses to lose sync
  localparam logic [2:0] GOOD_LIMIT = 3'h5;  // hits to regain sync
  localparam logic [3:0] SCR_PERIOD = 4'h8;  // packets per group
  localparam logic [7:0] RS_T = 8'h08;       // correctable bytes

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;      // byte clock rate
  localparam int ERR_HOLD_MS = 300;  // least error lamp on-time
  localparam int LOSS_US = 10;       // silence before input loss
  localparam int ERR_HOLD_CYC = ERR_HOLD_MS * 1000 * CLK_MHZ;
  localparam int LOSS_CYC = LOSS_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic input_loss; // no bytes arriving
    logic sync_loss;  // packet sync lost
    logic len188;     // short packets
    logic len204;     // long packets
    logic rs_err;     // uncorrectable packet seen
    logic scram;      // energy dispersal present
    logic rs_present; // parity bytes present
  } led_t;

  typedef struct packed {
    logic dec_ilv; // de-interleave
    logic dec_rs;  // rs decode
    logic dec_scr; // de-scramble
    logic enc_ilv; // interleave
    logic enc_rs;  // rs encode
    logic enc_scr; // scramble
  } proc_en_t;

endpackage

// ### retrig_hold.sv
// retriggerable hold: output stays high for a count after each trigger
`timescale 1ns/10ps
module retrig_hold #(
  parameter int COUNT = 16 // hold length in clock cycles
) (
  input wire logic clock,   // byte clock
  input wire logic arst_n,  // async reset, low
  input wire logic trigger, // restarts the hold
  output logic active       // high while holding
);
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] left; // cycles remaining

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // reload on trigger, else count down to zero
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left <= '0;
      active <= 1'b0;
    end
    else if (trigger)
    begin
      left <= LAST;
      active <= 1'b1;
    end
    else if (left != '0)
    begin
      left <= left - W'(1);
    end
    else
    begin
      active <= 1'b0;
    end
  end
endmodule

// ### ts_input_status_monitor.sv
// transport stream input status monitor with axi4-lite registers
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module ts_input_status_monitor #(
  parameter int ERR_HOLD = ts_mon_pkg::ERR_HOLD_CYC, // error hold cycles
  parameter int LOSS_HOLD = ts_mon_pkg::LOSS_CYC     // silence cycles
) (
  input wire logic clock,                   // 200 mhz byte clock
  input wire logic arst_n,                  // async reset, low
  input wire logic [3:0] s_axi_awaddr,      // write address
  input wire logic s_axi_awvalid,           // write address valid
  output logic s_axi_awready,               // write address ready
  input wire logic [31:0] s_axi_wdata,      // write data
  input wire logic [3:0] s_axi_wstrb,       // write strobes
  input wire logic s_axi_wvalid,            // write data valid
  output logic s_axi_wready,                // write data ready
  output logic [1:0] s_axi_bresp,           // write response
  output logic s_axi_bvalid,                // write response valid
  input wire logic s_axi_bready,            // write response ready
  input wire logic [3:0] s_axi_araddr,      // read address
  input wire logic s_axi_arvalid,           // read address valid
  output logic s_axi_arready,               // read address ready
  output logic [31:0] s_axi_rdata,          // read data
  output logic [1:0] s_axi_rresp,           // read response
  output logic s_axi_rvalid,                // read data valid
  input wire logic s_axi_rready,            // read data ready
  input wire logic byte_valid,              // aligned byte strobe
  input wire logic [7:0] byte_data,         // aligned stream byte
  input wire logic rs_pkt_done,             // decoder packet end
  input wire logic [7:0] rs_pkt_errs,       // bad bytes in packet
  input wire logic g703_valid,              // telecom output valid
  output ts_mon_pkg::led_t leds,            // front lamps
  output logic relay_close,                 // close com to n/o
  output ts_mon_pkg::proc_en_t proc_en      // path enables
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {HUNT, CHECK, TRACK} sync_state_t;

  sync_state_t state;          // sync tracker state
  logic [7:0] pos;             // byte position, 0 is sync
  logic [7:0] len;             // locked packet length
  logic [2:0] miss_run;        // consecutive missed syncs
  logic [2:0] good_run;        // consecutive good syncs
  logic sync_lost;             // sync loss condition
  logic [3:0] since_inv;       // packets since inverted sync
  logic scram;                 // scrambling detected
  logic tail_nz;               // nonzero byte in tail
  logic rs_present;            // parity detected
  logic [8:0] ctrl;            // control register
  logic rx_active;             // bytes seen recently
  logic err_hold;              // error lamp stretch
  logic input_lost;            // no input
  logic blank;                 // lamps blanked
  logic is_sync;               // byte is a sync value
  logic at_sync;               // byte at expected sync slot
  logic [3:0] aw_addr;         // held write address
  logic aw_full;               // write address held
  logic [31:0] w_data;         // held write data
  logic [3:0] w_strb;          // held write strobes
  logic w_full;                // write data held
  logic uncorrectable;         // packet beyond correction

  assign is_sync = (byte_data == ts_mon_pkg::SYNC_BYTE) ||
                   (byte_data == ts_mon_pkg::SYNC_INV);
  assign at_sync = byte_valid && (state == TRACK) && (pos == 8'h00);
  assign input_lost = !rx_active;
  assign blank = input_lost || sync_lost;
  assign uncorrectable = rs_pkt_done && (rs_pkt_errs > ts_mon_pkg::RS_T);

  // ---------------------------------------------------------------
  // activity and error stretchers
  // ---------------------------------------------------------------
  // bytes keep the activity hold alive
  retrig_hold #(
    .COUNT(LOSS_HOLD)
  ) u_loss (
    .clock(clock),
    .arst_n(arst_n),
    .trigger(byte_valid),
    .active(rx_active)
  );

  // each uncorrectable packet restarts the lamp hold
  retrig_hold #(
    .COUNT(ERR_HOLD)
  ) u_err (
    .clock(clock),
    .arst_n(arst_n),
    .trigger(uncorrectable),
    .active(err_hold)
  );

  // ---------------------------------------------------------------
  // packet sync tracker
  // ---------------------------------------------------------------
  // hunt for a sync, confirm spacing, then track slots
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= HUNT;
      pos <= 8'h00;
      len <= ts_mon_pkg::LEN_SHORT;
    end
    else if (input_lost && !byte_valid)
    begin
      state <= HUNT;
      pos <= 8'h00;
    end
    else if (byte_valid)
    begin
      case (state)
        HUNT:
        begin
          // first candidate sync starts a spacing check
          if (is_sync)
          begin
            state <= CHECK;
            pos <= 8'h01;
          end
        end
        CHECK:
        begin
          // a sync exactly 188 or 204 bytes later fixes length
          if (is_sync && pos == ts_mon_pkg::LEN_SHORT)
          begin
            state <= TRACK;
            len <= ts_mon_pkg::LEN_SHORT;
            pos <= 8'h01;
          end
          else if (pos == ts_mon_pkg::LEN_LONG)
          begin
            state <= is_sync ? TRACK : HUNT;
            len <= ts_mon_pkg::LEN_LONG;
            pos <= 8'h01;
          end
          else
          begin
            pos <= pos + 8'h01;
          end
        end
        TRACK:
        begin
          // lost sync sends us back to hunting
          if (pos == 8'h00 && !is_sync && miss_run == 3'h1)
          begin
            state <= HUNT;
            pos <= 8'h00;
          end
          else
          begin
            pos <= (pos == len - 8'h01) ? 8'h00 : pos + 8'h01;
          end
        end
        default:
        begin
          state <= HUNT;
          pos <= 8'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sync loss and recovery counts
  // ---------------------------------------------------------------
  // loss after two misses, recovery after five hits
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      miss_run <= 3'h0;
      good_run <= 3'h0;
      sync_lost <= 1'b1;
    end
    else if (input_lost && !byte_valid)
    begin
      miss_run <= 3'h0;
      good_run <= 3'h0;
      sync_lost <= 1'b1;
    end
    else if (byte_valid && state == CHECK && is_sync &&
             (pos == ts_mon_pkg::LEN_SHORT || pos == ts_mon_pkg::LEN_LONG))
    begin
      // the confirming sync is the second good one in a row
      good_run <= 3'h2;
      miss_run <= 3'h0;
    end
    else if (at_sync && is_sync)
    begin
      miss_run <= 3'h0;
      if (good_run != ts_mon_pkg::GOOD_LIMIT)
      begin
        good_run <= good_run + 3'h1;
      end
      if (good_run + 3'h1 >= ts_mon_pkg::GOOD_LIMIT)
      begin
        sync_lost <= 1'b0;
      end
    end
    else if (at_sync)
    begin
      good_run <= 3'h0;
      miss_run <= miss_run + 3'h1;
      if (miss_run + 3'h1 >= ts_mon_pkg::MISS_LIMIT)
      begin
        sync_lost <= 1'b1;
        miss_run <= 3'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // scrambling detector
  // ---------------------------------------------------------------
  // inverted sync must recur exactly every eighth packet
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      since_inv <= 4'h0;
      scram <= 1'b0;
    end
    else if (blank && !at_sync)
    begin
      since_inv <= 4'h0;
      scram <= 1'b0;
    end
    else if (at_sync && byte_data == ts_mon_pkg::SYNC_INV)
    begin
      scram <= (since_inv == ts_mon_pkg::SCR_PERIOD);
      since_inv <= 4'h1;
    end
    else if (at_sync && byte_data == ts_mon_pkg::SYNC_BYTE)
    begin
      // an eighth plain sync in a row means no scrambling group
      if (since_inv >= ts_mon_pkg::SCR_PERIOD)
      begin
        scram <= 1'b0;
      end
      if (since_inv != 4'hf)
      begin
        since_inv <= since_inv + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // parity presence detector
  // ---------------------------------------------------------------
  // or the sixteen trailing bytes of long packets together
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tail_nz <= 1'b0;
      rs_present <= 1'b0;
    end
    else if (state != TRACK || len != ts_mon_pkg::LEN_LONG)
    begin
      tail_nz <= 1'b0;
      rs_present <= 1'b0;
    end
    else if (at_sync)
    begin
      // packet boundary: judge the finished tail
      rs_present <= tail_nz;
      tail_nz <= 1'b0;
    end
    else if (byte_valid && pos >= ts_mon_pkg::LEN_SHORT)
    begin
      tail_nz <= tail_nz || (byte_data != 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // lamps, relay and path enables
  // ---------------------------------------------------------------
  // every output registered; all lamps but the two loss lamps dark while blanked
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      leds <= '0;
      relay_close <= 1'b0;
    end
    else
    begin
      leds.input_loss <= input_lost;
      leds.sync_loss <= sync_lost;
      leds.len188 <= !blank && len == ts_mon_pkg::LEN_SHORT;
      leds.len204 <= !blank && len == ts_mon_pkg::LEN_LONG;
      leds.rs_err <= !blank && err_hold;
      leds.scram <= !blank && scram;
      leds.rs_present <= !blank && rs_present;
      if (ctrl[ts_mon_pkg::LINK_POS])
      begin
        relay_close <= !g703_valid;
      end
      else
      begin
        relay_close <= sync_lost;
      end
    end
  end

  // decode each selection into one path or neither
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      proc_en <= '0;
    end
    else
    begin
      proc_en.dec_ilv <= ctrl[ts_mon_pkg::ILV_SEL_POS +: 2] == ts_mon_pkg::SEL_UP;
      proc_en.dec_rs <= ctrl[ts_mon_pkg::RS_SEL_POS +: 2] == ts_mon_pkg::SEL_UP;
      proc_en.dec_scr <= ctrl[ts_mon_pkg::SCR_SEL_POS +: 2] == ts_mon_pkg::SEL_UP;
      proc_en.enc_ilv <= ctrl[ts_mon_pkg::ILV_SEL_POS +: 2] == ts_mon_pkg::SEL_DOWN;
      proc_en.enc_rs <= ctrl[ts_mon_pkg::RS_SEL_POS +: 2] == ts_mon_pkg::SEL_DOWN;
      proc_en.enc_scr <= ctrl[ts_mon_pkg::SCR_SEL_POS +: 2] == ts_mon_pkg::SEL_DOWN;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  // address and data taken in any order, answer when both held
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ts_mon_pkg::RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      ctrl <= ts_mon_pkg::CTRL_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full && w_full && !s_axi_bvalid)
      begin
        // perform the write and raise the response
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ts_mon_pkg::RESP_OKAY;
        if (aw_addr == ts_mon_pkg::CTRL_OFS)
        begin
          if (w_strb[0])
          begin
            ctrl[7:0] <= w_data[7:0];
          end
          if (w_strb[1])
          begin
            ctrl[8] <= w_data[8];
          end
        end
        else if (aw_addr != ts_mon_pkg::STATUS_OFS)
        begin
          s_axi_bresp <= ts_mon_pkg::RESP_SLVERR; // unmapped
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  // data one cycle after the address is taken
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ts_mon_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ts_mon_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ts_mon_pkg::CTRL_OFS: s_axi_rdata <= {23'h0, ctrl};
        ts_mon_pkg::STATUS_OFS: s_axi_rdata <= {16'h0, len, 1'b0, leds};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= ts_mon_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### ts_mon_checker_properties.sv
// checker: properties on the monitor ports
`timescale 1ns/10ps
module ts_mon_checker #(
  parameter int ERR_HOLD = 50, // error hold cycles
  parameter int LOSS_HOLD = 20 // silence cycles
) (
  input wire logic clock, // byte clock
  input wire logic arst_n, // async reset, low
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic byte_valid, // byte strobe
  input wire logic rs_pkt_done, // packet end
  input wire logic [7:0] rs_pkt_errs, // bad bytes
  input wire logic g703_valid, // telecom valid
  input wire ts_mon_pkg::led_t leds, // lamps
  input wire logic relay_close, // alarm contact
  input wire ts_mon_pkg::proc_en_t proc_en // path enables
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----
  // helper logic
  // ----
  logic [5:0] sel; // shadow switch fields
  logic link; // shadow alarm link
  int hold_cnt; // cycles since last fault
  int quiet_cnt; // cycles without bytes
  logic blank; // loss lamps lit
  logic trig; // uncorrectable packet
  assign blank = leds.input_loss | leds.sync_loss;
  assign trig = rs_pkt_done && (rs_pkt_errs > 8'h08);
  // shadow of whole control writes
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      {link, sel} <= 7'h00;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == ts_mon_pkg::CTRL_OFS)
      {link, sel} <= {s_axi_wdata[8], s_axi_wdata[5:0]};
  // age of latest fault
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      hold_cnt <= 0;
    else
      hold_cnt <= trig ? 1 : (hold_cnt != 0 && hold_cnt < ERR_HOLD) ? hold_cnt + 1 : hold_cnt;
  // silence length, saturating
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      quiet_cnt <= 0;
    else
      quiet_cnt <= byte_valid ? 0 : (quiet_cnt < LOSS_HOLD + 3) ? quiet_cnt + 1 : quiet_cnt;
  // expected enables for a switch word
  function automatic logic [5:0] dec(input logic [5:0] s);
    return {s[1:0] == 2'h1, s[3:2] == 2'h1, s[5:4] == 2'h1,
            s[1:0] == 2'h2, s[3:2] == 2'h2, s[5:4] == 2'h2};
  endfunction
  // ----
  // properties
  // ----
  property p_blank;
    blank && $past(blank) |-> leds[4:0] == 5'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("lamp lit during loss");
  property p_len;
    !(leds.len188 && leds.len204);
  endproperty
  a_len: assert property (p_len) else $error("both length lamps lit");
  property p_rs_set;
    trig |-> ##2 (leds.rs_err || blank);
  endproperty
  a_rs_set: assert property (p_rs_set) else $error("error lamp not lit");
  property p_rs_hold;
    hold_cnt >= 2 && hold_cnt <= ERR_HOLD - 2 && !blank && $past(!blank) |-> leds.rs_err;
  endproperty
  a_rs_hold: assert property (p_rs_hold) else $error("error lamp dropped early");
  property p_loss_set;
    quiet_cnt == LOSS_HOLD + 3 |-> leds.input_loss;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("silence not flagged");
  property p_loss_clr;
    byte_valid |-> ##[1:2] !leds.input_loss;
  endproperty
  a_loss_clr: assert property (p_loss_clr) else $error("loss kept with data");
  property p_proc;
    s_axi_bvalid |=> proc_en == dec(sel);
  endproperty
  a_proc: assert property (p_proc) else $error("path enables wrong");
  property p_relay_sync;
    !link && !$past(link, 2) && $stable(leds.sync_loss) |-> relay_close == leds.sync_loss;
  endproperty
  a_relay_sync: assert property (p_relay_sync) else $error("relay not on sync");
  property p_relay_tel;
    link && $past(link, 2) && $stable(g703_valid) |-> relay_close == !g703_valid;
  endproperty
  a_relay_tel: assert property (p_relay_tel) else $error("relay not on output");
  c_regain: cover property ($fell(leds.sync_loss));
  c_rs: cover property ($rose(leds.rs_err));
  c_scram: cover property (leds.scram && leds.len204);
endmodule
bind ts_input_status_monitor ts_mon_checker #(.ERR_HOLD(ERR_HOLD), .LOSS_HOLD(LOSS_HOLD)) chk_u (
  .clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .byte_valid, .rs_pkt_done, .rs_pkt_errs, .g703_valid, .leds,
  .relay_close, .proc_en);

// ### ts_byte_src.sv
// partner model: byte-aligned stream source
`timescale 1ns/10ps
module ts_byte_src (
  input wire logic clock, // byte clock
  output logic byte_valid, // byte strobe
  output logic [7:0] byte_data // stream byte
);
  initial
  begin
    byte_valid = 1'b0;
    byte_data = 8'h5a;
  end
  // ----
  // one packet: sync, body, tail on long packets; gap slows the rate
  // ----
  task automatic send_pkt(input logic [7:0] sync, input int len, input logic [7:0] tail,
                          input int gap);
    logic [7:0] b;
    for (int i = 0; i < len; i++)
    begin
      b = (i == 0) ? sync : (len == 204 && i >= 188) ? tail : 8'h11;
      @(posedge clock);
      byte_valid <= 1'b1;
      byte_data <= b;
      if (gap > 0 || i == len - 1)
      begin
        @(posedge clock);
        byte_valid <= 1'b0;
        byte_data <= ~b; // idle line never repeats the last byte
        repeat (gap) @(posedge clock);
      end
    end
  endtask
endmodule

// ### ts_input_status_monitor_tb.sv
// testbench: register and stream scenarios
`timescale 1ns/10ps
module ts_input_status_monitor_tb;
  localparam int EH = 50; // short error hold
  localparam int LH = 300; // short silence limit
  localparam logic [3:0] CT = ts_mon_pkg::CTRL_OFS, ST = ts_mon_pkg::STATUS_OFS; // offsets
  logic clock = 1'b0, arst_n = 1'b0; // clock, reset
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf; // bus inputs
  logic [31:0] s_axi_wdata = 32'h0; // write data
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write handshake
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // read handshake
  logic rs_pkt_done = 1'b0, g703_valid = 1'b1; // decoder and telecom status
  logic [7:0] rs_pkt_errs = 8'h00, byte_data; // error count, stream
  logic byte_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp; // responses
  logic [31:0] s_axi_rdata, rd; // read data
  logic relay_close; // alarm contact
  ts_mon_pkg::led_t leds; // lamps
  ts_mon_pkg::proc_en_t proc_en; // path enables
  int err_total = 0, total_checks = 0; // tallies
  always #2.5 clock = ~clock;
  ts_byte_src src_u (.clock, .byte_valid, .byte_data);
  ts_input_status_monitor #(.ERR_HOLD(EH), .LOSS_HOLD(LH)) dut_u (
    .clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .byte_valid, .byte_data, .rs_pkt_done, .rs_pkt_errs, .g703_valid, .leds,
    .relay_close, .proc_en);
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write: aw and w together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(negedge clock); // let registered outputs settle
  endtask
  // read: result left in rd and rsp
  task automatic axi_rd(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse_err(input logic [7:0] e);
    @(posedge clock);
    rs_pkt_done <= 1'b1;
    rs_pkt_errs <= e;
    @(posedge clock);
    rs_pkt_done <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(leds, 7'h60);
    chk(relay_close, 1'b1);
    for (int p = 0; p < 4; p++)
    begin
      axi_wr(CT, {26'h0, p[1:0], p[1:0], p[1:0]});
      chk(proc_en, {{3{p == 1}}, {3{p == 2}}});
    end
    axi_wr(CT, 32'h09);
    chk(proc_en, 6'h22);
    axi_rd(CT);
    chk(rd, 32'h09);
    axi_rd(ST);
    chk(rd[7:0], 8'h60);
    axi_rd(4'hc);
    chk({rsp, rd}, {ts_mon_pkg::RESP_SLVERR, 32'h0});
    axi_wr(ST, 32'hff);
    chk(s_axi_bresp, ts_mon_pkg::RESP_OKAY);
    axi_wr(CT, 32'h0);
    repeat (4) src_u.send_pkt(8'h47, 188, 8'h00, 0);
    chk(leds.sync_loss, 1'b1);
    src_u.send_pkt(8'h47, 188, 8'h00, 0);
    chk(leds, 7'h10);
    chk(relay_close, 1'b0);
    axi_rd(ST);
    chk(rd[15:8], ts_mon_pkg::LEN_SHORT);
    src_u.send_pkt(8'h00, 188, 8'h00, 0);
    chk(leds.sync_loss, 1'b0);
    src_u.send_pkt(8'h00, 188, 8'h00, 0);
    chk(leds, 7'h20);
    chk(relay_close, 1'b1);
    repeat (6) src_u.send_pkt(8'h47, 204, 8'h00, 1);
    chk(leds, 7'h08);
    repeat (2) src_u.send_pkt(8'h47, 204, 8'h5a, 0);
    chk(leds.rs_present, 1'b1);
    for (int i = 0; i < 9; i++)
      src_u.send_pkt((i % 8 == 0) ? 8'hb8 : 8'h47, 204, 8'h5a, 0);
    chk(leds, 7'h0b);
    pulse_err(8'h08);
    repeat (3) @(posedge clock);
    chk(leds.rs_err, 1'b0);
    pulse_err(8'h09);
    repeat (40) @(posedge clock);
    pulse_err(8'h09);
    repeat (45) @(posedge clock);
    chk(leds.rs_err, 1'b1);
    repeat (15) @(posedge clock);
    chk(leds.rs_err, 1'b0);
    repeat (LH) @(posedge clock);
    chk(leds.input_loss, 1'b1);
    chk(leds[4:0], 5'h00);
    src_u.send_pkt(8'h47, 188, 8'h00, 0);
    chk(leds.input_loss, 1'b0);
    axi_wr(CT, 32'h100);
    repeat (3) @(posedge clock);
    chk(relay_close, 1'b0);
    g703_valid <= 1'b0;
    repeat (3) @(posedge clock);
    chk(relay_close, 1'b1);
    conclude();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (40000) @(posedge clock);
    err_total++;
    conclude();
  end
endmodule
